// ===== scc_cpu_model.sv
`timescale 1ns/1ns
// cpu core stand-in on the card bus
module scc_cpu_model
(
  input wire logic clk_i,
  input wire logic wait_n_i,
  input wire logic busreq_n_i,
  input wire logic [7:0] data_i,
  output scc_pkg::scc_cpu_t cpu_o,
  output logic [7:0] data_o,
  output logic grant_n_o
);
  import scc_pkg::*;
  // ****************************************
  // idle bus and takeover grant
  // ****************************************
  initial
  begin
    cpu_o = '1;
    data_o = 8'h00;
    grant_n_o = 1'b1;
  end
  // grant one edge after the request
  always @(posedge clk_i)
    grant_n_o <= busreq_n_i;
  // ****************************************
  // bus cycle: kind 0 port write, 1 port read, 2 acknowledge, 3 memory write
  // ****************************************
  // cycles run whole, one after another: an interrupt could only be taken between them
  task automatic cyc(input logic [7:0] a, input logic [7:0] d, input int kind, output logic [7:0] q);
    @(posedge clk_i);
    cpu_o.addr <= {8'h00, a};
    cpu_o.wdata <= d;
    data_o <= d;
    cpu_o.port_request_n <= (kind == 3);
    cpu_o.memory_request_n <= (kind != 3);
    cpu_o.opcode_fetch_cycle_n <= (kind != 2);
    cpu_o.wr_n <= (kind == 1 || kind == 2);
    cpu_o.rd_n <= (kind != 1);
    @(posedge clk_i);
    // stretch while the device holds wait, looked at mid-cycle where it has settled
    @(negedge clk_i);
    while (!wait_n_i)
      @(negedge clk_i);
    q = data_i;
    @(posedge clk_i);
    cpu_o <= '1;
    // released bus does not keep its last value
    data_o <= ~d;
  endtask : cyc
endmodule : scc_cpu_model

// ===== scc_cyc_decode.sv
`timescale 1ns/1ns
`include "scc_map.svh"
// classifies one cpu bus cycle from its strobes
module scc_cyc_decode
(
  input wire scc_pkg::scc_cpu_t cpu_i,
  output scc_pkg::scc_cyc_t kind_o
);
  import scc_pkg::*;
  // ****************************************
  // decode
  // ****************************************
  always_comb
  begin
    kind_o = SCC_IDLE;
    // port request with fetch is acknowledge, never a port access
    if (!cpu_i.port_request_n && !cpu_i.opcode_fetch_cycle_n)
    begin
      kind_o = SCC_IACK; // R5
    end
    else if (!cpu_i.port_request_n)
    begin
      // only the low address byte counts for ports
      if (!cpu_i.rd_n)
      begin
        kind_o = SCC_IO_RD;
      end
      else if (!cpu_i.wr_n)
      begin
        kind_o = SCC_IO_WR;
      end
    end
    else if (!cpu_i.memory_request_n)
    begin
      if (!cpu_i.opcode_fetch_cycle_n)
      begin
        kind_o = SCC_FETCH; // R3
      end
      else if (!cpu_i.rd_n)
      begin
        kind_o = SCC_MEM_RD; // R4
      end
      else if (!cpu_i.wr_n)
      begin
        kind_o = SCC_MEM_WR;
      end
    end
  end
endmodule : scc_cyc_decode

// ===== scc_map.svh
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
// ****************************************
// register offsets (byte addr, word index = byte addr / 4)
// ****************************************
`define SCC_OFF_CTRL 8'h00
`define SCC_OFF_STAT 8'h04
`define SCC_OFF_CYC 8'h08
// ****************************************
// control word field positions
// ****************************************
`define SCC_BIT_WAIT 0
`define SCC_BIT_BUSREQ 1
// ****************************************
// serial port select: channel control ports on the low address byte
// ****************************************
`define SCC_PORT_C0A_CTL 8'h71
`define SCC_PORT_C0B_CTL 8'h73
`define SCC_PORT_C1A_CTL 8'h75
`define SCC_PORT_C1B_CTL 8'h77
// ****************************************
// tx control and buffer status register numbers and bits
// ****************************************
`define SCC_REG_TXCTL 3'h5
`define SCC_REG_BUFST 3'h0
`define SCC_TX_BIT_LO 1
`define SCC_TX_BIT_HI 7
`define SCC_HOOD_BIT 5
// ****************************************
// reset values of the special-function outputs
// ****************************************
`define SCC_RST_SED_N 1'b1
`define SCC_RST_DIFF 1'b1
`define SCC_RST_LED 1'b1
`define SCC_RST_LOOP_N 1'b1
`define SCC_RST_LAMP_N 1'b1
// ****************************************
// timing
// ****************************************
`define SCC_CPU_CLK_KHZ 3686
`define SCC_CPU_CLK_MAX_KHZ 4000
`define SCC_SYS_CLK_KHZ 10000
`endif

// ===== scc_pkg.sv
package scc_pkg;
  // cpu bus strobes, all active low
  typedef struct packed {
    logic [15:0] addr;
    logic opcode_fetch_cycle_n;
    logic memory_request_n;
    logic port_request_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] wdata;
  } scc_cpu_t;
  // decoded cycle kinds
  typedef enum logic [2:0] {
    SCC_IDLE,
    SCC_MEM_RD,
    SCC_MEM_WR,
    SCC_IO_RD,
    SCC_IO_WR,
    SCC_IACK,
    SCC_FETCH
  } scc_cyc_t;
  // special-function outputs
  typedef struct packed {
    logic single_ended_drive_on_n;
    logic differential_drive_on;
    logic led_a;
    logic led_b;
    logic loop_n;
    logic hood_lamp_n;
  } scc_sfo_t;
endpackage : scc_pkg

// ===== scc_port_regs.sv
`timescale 1ns/1ns
`include "scc_map.svh"
// per-channel pointer register: which internal register the next access hits
module scc_port_regs
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] sel_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [11:0] ptr_o
);
  import scc_pkg::*;
  // ****************************************
  // pointer state, one 3-bit field per channel
  // ****************************************
  typedef struct packed {
    logic [11:0] ptr;
  } scc_ptr_st_t;
  scc_ptr_st_t st_ff; // registered state
  scc_ptr_st_t nxt_st; // next state
  // pointer written in reg 0, reset to 0 after any other write
  always_comb
  begin
    nxt_st = st_ff;
    for (int i = 0; i < 4; i++)
    begin
      if (wr_i && sel_i[i])
      begin
        if (st_ff.ptr[i*3 +: 3] == 3'h0)
        begin
          nxt_st.ptr[i*3 +: 3] = wdata_i[2:0]; // R12
        end
        else
        begin
          nxt_st.ptr[i*3 +: 3] = 3'h0;
        end
      end
    end
  end
  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
  assign ptr_o = st_ff.ptr;
endmodule : scc_port_regs

// ===== scc_top.sv
`timescale 1ns/1ns
`include "scc_map.svh"
// What the document requires of the card, its cpu and its software
// R1: cpu drives 16-bit memory, 8-bit port address
// R2: single 8-bit bidirectional active-high data bus
// R3: opcode fetch low for whole fetch cycle
// R4: memory request only with valid address
// R5: port request with fetch means acknowledge
// R6: drive read data only during read strobe
// R7: cpu holds write data during write strobe
// R8: hold wait low until transfer can complete
// R9: cpu takes interrupt at instruction end
// R10: bus request answered by grant and release
// R11: cpu clock 3.6864 MHz, below 4 MHz
// R12: pointer register selects next channel register
// R13: bit1 chan A ctl0 enables single-ended drivers
// R14: bit7 zero chan B ctl0 enables differential
// R15: bit1 zero both chan B lights LED
// R16: software sets both LED shunts close together
// R17: bit7 chan A ctl0 asserts loop-back
// R18: one loop-back control for all channels
// R19: loop-back disables all frontplane receivers
// R20: software disables drivers before loop-back
// R21: hood sense reads on status bit 5
// R22: software toggles hood lamp to probe hood
// R23: bit7 chan B ctl1 lights hood lamp
// R24: outputs change at write completion, hold
module scc_top
(
  input wire logic clk_i,
  input wire logic rst_i,
  // cpu side bus
  input wire scc_pkg::scc_cpu_t cpu_i,
  input wire logic [7:0] cpu_data_i,
  output logic [7:0] cpu_data_o,
  output logic cpu_data_oe_o,
  output logic wait_n_o,
  output logic bus_takeover_request_n_o,
  input wire logic bus_takeover_grant_n_i,
  // board pins
  input wire logic hood_on_n_i,
  output scc_pkg::scc_sfo_t sfo_o,
  output logic rx_enable_o,
  output logic [2:0] cycle_kind_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import scc_pkg::*;
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    scc_sfo_t sfo; // special-function outputs
    logic [1:0] ctrl; // wait hold, bus request
    logic ack; // wishbone ack
    logic [31:0] rdat; // wishbone read data
    logic [7:0] cdat; // cpu read data
    logic wr_d; // previous write strobe level
    logic [7:0] last_port; // last port address written
    logic [7:0] last_data; // last port data
    logic [2:0] kind; // last decoded kind
  } scc_st_t;
  scc_st_t st_ff; // registered state
  scc_st_t nxt_st; // next state
  scc_cyc_t kind; // current cycle kind
  logic [11:0] ptr; // channel pointers
  logic [3:0] port_sel; // control port hit
  logic wr_end; // end of port write
  logic rd_act; // port read active
  // ****************************************
  // submodules
  // ****************************************
  scc_cyc_decode u_dec
  (
    .cpu_i(cpu_i),
    .kind_o(kind)
  );
  scc_port_regs u_ptr
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(port_sel),
    .wr_i(wr_end),
    .wdata_i(st_ff.last_data),
    .ptr_o(ptr)
  );
  // ****************************************
  // port decode
  // ****************************************
  // control port match on low address byte only
  always_comb
  begin
    port_sel = 4'h0;
    case (st_ff.last_port)
      `SCC_PORT_C0A_CTL: port_sel = 4'h1; // R1
      `SCC_PORT_C0B_CTL: port_sel = 4'h2;
      `SCC_PORT_C1A_CTL: port_sel = 4'h4;
      `SCC_PORT_C1B_CTL: port_sel = 4'h8;
      default: port_sel = 4'h0;
    endcase
  end
  // write completes on the rising write strobe of a port write; iack and memory writes never count
  // strobes are looked at every system clock of 10 mhz, two and a half times the cpu clock of at most 4 mhz, so none slips by
  assign wr_end = !st_ff.wr_d && cpu_i.wr_n && cpu_i.opcode_fetch_cycle_n && (st_ff.kind == SCC_IO_WR)
    && (|port_sel); // R24 R11
  assign rd_act = (kind == SCC_IO_RD) && !cpu_i.rd_n;
  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.wr_d = cpu_i.wr_n;
    // idle cycles keep the last bus kind, so software can still read it afterwards
    if (kind != SCC_IDLE)
    begin
      nxt_st.kind = kind;
    end
    nxt_st.ack = 1'b0;
    // capture address and data while the write strobe is low
    if (kind == SCC_IO_WR)
    begin
      nxt_st.last_port = cpu_i.addr[7:0]; // R7
      nxt_st.last_data = cpu_data_i;
    end
    // tx control register writes steer the outputs
    if (wr_end)
    begin
      if (port_sel[0] && ptr[2:0] == `SCC_REG_TXCTL)
      begin
        nxt_st.sfo.single_ended_drive_on_n = !st_ff.last_data[`SCC_TX_BIT_LO]; // R13
        nxt_st.sfo.loop_n = !st_ff.last_data[`SCC_TX_BIT_HI]; // R17
      end
      if (port_sel[1] && ptr[5:3] == `SCC_REG_TXCTL)
      begin
        nxt_st.sfo.differential_drive_on = !st_ff.last_data[`SCC_TX_BIT_HI]; // R14
        nxt_st.sfo.led_a = !st_ff.last_data[`SCC_TX_BIT_LO]; // R15
      end
      if (port_sel[3] && ptr[11:9] == `SCC_REG_TXCTL)
      begin
        nxt_st.sfo.led_b = !st_ff.last_data[`SCC_TX_BIT_LO]; // R15
        nxt_st.sfo.hood_lamp_n = !st_ff.last_data[`SCC_TX_BIT_HI]; // R23
      end
    end
    // buffer status read: hood sense on bit 5, 1 means pulled low
    nxt_st.cdat = 8'h00;
    if (!cpu_i.port_request_n && cpu_i.addr[7:0] == `SCC_PORT_C0B_CTL && ptr[5:3] == `SCC_REG_BUFST)
    begin
      nxt_st.cdat[`SCC_HOOD_BIT] = !hood_on_n_i; // R21
    end
    // wishbone single-cycle slave
    if (wb_cyc_i && wb_stb_i && !st_ff.ack)
    begin
      nxt_st.ack = 1'b1;
      case (wb_adr_i)
        `SCC_OFF_CTRL:
        begin
          if (wb_we_i && wb_sel_i[0])
          begin
            nxt_st.ctrl = wb_dat_i[1:0];
          end
          nxt_st.rdat = {30'h0, st_ff.ctrl};
        end
        `SCC_OFF_STAT: nxt_st.rdat = {24'h0, !bus_takeover_grant_n_i, !hood_on_n_i, st_ff.sfo};
        `SCC_OFF_CYC: nxt_st.rdat = {24'h0, st_ff.last_port[4:0], st_ff.kind};
        default: nxt_st.rdat = 32'h0;
      endcase
    end
  end
  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff.sfo <= {`SCC_RST_SED_N, `SCC_RST_DIFF, `SCC_RST_LED, `SCC_RST_LED, `SCC_RST_LOOP_N, `SCC_RST_LAMP_N};
      st_ff.ctrl <= 2'h0;
      st_ff.ack <= 1'b0;
      st_ff.rdat <= 32'h0;
      st_ff.cdat <= 8'h00;
      st_ff.wr_d <= 1'b1;
      st_ff.last_port <= 8'h00;
      st_ff.last_data <= 8'h00;
      st_ff.kind <= 3'h0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  assign sfo_o = st_ff.sfo;
  // loop-back isolates the card: receivers off for all channels at once
  assign rx_enable_o = st_ff.sfo.loop_n; // R18 R19
  assign cpu_data_o = st_ff.cdat;
  // drive data only while read strobe low; never during grant
  assign cpu_data_oe_o = rd_act && bus_takeover_grant_n_i; // R6 R2 R10
  // software may stretch cpu cycles; wait stays low while held
  assign wait_n_o = !st_ff.ctrl[`SCC_BIT_WAIT]; // R8
  assign bus_takeover_request_n_o = !st_ff.ctrl[`SCC_BIT_BUSREQ]; // R10
  assign cycle_kind_o = st_ff.kind;
  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdat;
  // ****************************************
  // checks
  // ****************************************
  // data driven only with read strobe low
  property p_rd_gate;
    @(posedge clk_i) disable iff (rst_i) cpu_data_oe_o |-> !cpu_i.rd_n;
  endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("data driven outside read"); // R6
  // acknowledge is never a port read
  property p_iack;
    @(posedge clk_i) disable iff (rst_i) (!cpu_i.port_request_n && !cpu_i.opcode_fetch_cycle_n) |-> !cpu_data_oe_o;
  endproperty
  a_iack: assert property (p_iack) else $error("iack treated as port"); // R5
  // receivers off while looped
  property p_loop_rx;
    @(posedge clk_i) disable iff (rst_i) !sfo_o.loop_n |-> !rx_enable_o;
  endproperty
  a_loop_rx: assert property (p_loop_rx) else $error("receivers on during loop"); // R19
  // outputs hold unless a write ended
  property p_hold;
    @(posedge clk_i) disable iff (rst_i) !wr_end |=> $stable(sfo_o);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed without write"); // R24
  // wait reflects control bit one cycle after write
  property p_wait;
    @(posedge clk_i) disable iff (rst_i) (wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == `SCC_OFF_CTRL
      && $past(wb_sel_i[0])) |-> wait_n_o == !$past(wb_dat_i[0]);
  endproperty
  a_wait: assert property (p_wait) else $error("wait not following control"); // R8
  // hood sense appears on status read
  property p_hood;
    @(posedge clk_i) disable iff (rst_i) (!cpu_i.port_request_n && cpu_i.addr[7:0] == `SCC_PORT_C0B_CTL
      && ptr[5:3] == 3'h0) |=> cpu_data_o[5] == !$past(hood_on_n_i);
  endproperty
  a_hood: assert property (p_hood) else $error("hood sense wrong"); // R21
  // single-ended enable follows bit 1 of chan A tx control write
  property p_sed;
    @(posedge clk_i) disable iff (rst_i) (wr_end && port_sel[0] && ptr[2:0] == 3'h5)
      |=> sfo_o.single_ended_drive_on_n == !$past(st_ff.last_data[1]);
  endproperty
  a_sed: assert property (p_sed) else $error("single-ended enable wrong"); // R13
  // differential enable follows inverted bit 7
  property p_diff;
    @(posedge clk_i) disable iff (rst_i) (wr_end && port_sel[1] && ptr[5:3] == 3'h5)
      |=> sfo_o.differential_drive_on == !$past(st_ff.last_data[7]);
  endproperty
  a_diff: assert property (p_diff) else $error("differential enable wrong"); // R14
  // wishbone ack is one cycle pulse
  property p_ack;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held"); // R10
  // loop-back follows bit 7 of chan A tx control write
  property p_loop;
    @(posedge clk_i) disable iff (rst_i) (wr_end && port_sel[0] && ptr[2:0] == 3'h5)
      |=> sfo_o.loop_n == !$past(st_ff.last_data[7]);
  endproperty
  a_loop: assert property (p_loop) else $error("loop-back control wrong"); // R17
  // first led shunt follows inverted bit 1 of chan B tx control write
  property p_led_a;
    @(posedge clk_i) disable iff (rst_i) (wr_end && port_sel[1] && ptr[5:3] == 3'h5)
      |=> sfo_o.led_a == !$past(st_ff.last_data[1]);
  endproperty
  a_led_a: assert property (p_led_a) else $error("first led shunt wrong"); // R15
  // second led shunt follows inverted bit 1 of the second controller's chan B
  property p_led_b;
    @(posedge clk_i) disable iff (rst_i) (wr_end && port_sel[3] && ptr[11:9] == 3'h5)
      |=> sfo_o.led_b == !$past(st_ff.last_data[1]);
  endproperty
  a_led_b: assert property (p_led_b) else $error("second led shunt wrong"); // R15
  // hood lamp follows bit 7 of the second controller's chan B
  property p_lamp;
    @(posedge clk_i) disable iff (rst_i) (wr_end && port_sel[3] && ptr[11:9] == 3'h5)
      |=> sfo_o.hood_lamp_n == !$past(st_ff.last_data[7]);
  endproperty
  a_lamp: assert property (p_lamp) else $error("hood lamp wrong"); // R23
  // receivers stay on while not looped
  property p_rx_on;
    @(posedge clk_i) disable iff (rst_i) sfo_o.loop_n |-> rx_enable_o;
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("receivers off without loop"); // R19
  // no data driven while the buses are granted away
  property p_grant_oe;
    @(posedge clk_i) disable iff (rst_i) !bus_takeover_grant_n_i |-> !cpu_data_oe_o;
  endproperty
  a_grant_oe: assert property (p_grant_oe) else $error("data driven during grant"); // R10
  // acknowledge cycles never touch the outputs
  property p_iack_hold;
    @(posedge clk_i) disable iff (rst_i) (!cpu_i.port_request_n && !cpu_i.opcode_fetch_cycle_n) |=> $stable(sfo_o);
  endproperty
  a_iack_hold: assert property (p_iack_hold) else $error("iack changed outputs"); // R5
endmodule : scc_top

// ===== tb_serial_card_control_lines.sv
`timescale 1ns/1ns
`include "scc_map.svh"
module tb_serial_card_control_lines;
  import scc_pkg::*;
  logic clk_i = 0, rst_i = 1, hood_on_n = 1, fitted = 0;
  logic wb_cyc = 0, wb_stb = 0, wb_we = 0;
  logic [7:0] wb_adr = 8'h00, rd;
  logic [31:0] wb_dat = 32'h0, q;
  scc_cpu_t cpu;
  logic [7:0] cdata, cdo;
  logic oe, wait_n, breq_n, gnt_n, rxen, ack;
  scc_sfo_t sfo;
  logic [2:0] kind;
  logic [31:0] wbq;
  logic [7:0] r5 [4]; // tx control shadow per port
  logic [7:0] port [4] = '{`SCC_PORT_C0A_CTL, `SCC_PORT_C0B_CTL, `SCC_PORT_C1A_CTL, `SCC_PORT_C1B_CTL};
  int n_errors = 0, num_checks = 0, seed = 99106, cycles = 0, i;
  // ****************************************
  // clock, timeout, board hood circuit
  // ****************************************
  initial
  begin
    forever #50 clk_i = ~clk_i;
  end
  // hang guard, a few hundred cycles expected
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  // fitted hood returns the lamp line inverted, else pulled high
  always @(posedge clk_i)
    hood_on_n <= fitted ? ~sfo.hood_lamp_n : 1'b1;
  scc_top i_scc_top (.clk_i(clk_i), .rst_i(rst_i), .cpu_i(cpu), .cpu_data_i(cdata), .cpu_data_o(cdo),
    .cpu_data_oe_o(oe), .wait_n_o(wait_n), .bus_takeover_request_n_o(breq_n), .bus_takeover_grant_n_i(gnt_n),
    .hood_on_n_i(hood_on_n), .sfo_o(sfo), .rx_enable_o(rxen), .cycle_kind_o(kind), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
    .wb_dat_o(wbq), .wb_ack_o(ack));
  scc_cpu_model i_scc_cpu_model (.clk_i(clk_i), .wait_n_i(wait_n), .busreq_n_i(breq_n), .data_i(cdo),
    .cpu_o(cpu), .data_o(cdata), .grant_n_o(gnt_n));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
      $display("BAD %0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      n_errors++;
  endtask : chk
  // classic single wishbone cycle, waits for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, we, a, d};
    // ack looked at mid-cycle where it has settled; only the bench timeout ends the wait
    do @(negedge clk_i); while (ack !== 1'b1);
    // the rising edge at which ack stands high: data taken there, released after it
    @(posedge clk_i);
    q = wbq;
    wb_cyc <= 0;
    wb_stb <= 0;
  endtask : wb
  // expected special-function levels from the shadow
  function automatic logic [5:0] exp_sfo();
    return {~r5[0][1], ~r5[1][7], ~r5[1][1], ~r5[3][1], ~r5[0][7], ~r5[3][7]};
  endfunction : exp_sfo
  // pointer write then register write, then compare outputs
  task automatic set_reg(input int p, input logic [2:0] r, input logic [7:0] d);
    // wrap only once both line drivers are off
    if (p == 0 && r == 3'h5 && d[7] && (d[1] || !r5[1][7]))
      d[7] = 1'b0;
    // second led shunt follows the first, written soon after it
    if (p == 3 && r == 3'h5)
      d[1] = r5[1][1];
    i_scc_cpu_model.cyc(port[p], {5'h00, r}, 0, rd);
    i_scc_cpu_model.cyc(port[p], d, 0, rd);
    if (r == 3'h5)
      r5[p] = d;
    repeat (2) @(posedge clk_i);
    chk(sfo, exp_sfo());
    chk(rxen, exp_sfo() >> 1 & 1);
    chk(kind, SCC_IO_WR);
  endtask : set_reg
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    r5 = '{8'h00, 8'h00, 8'h00, 8'h00};
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(negedge clk_i);
    chk(sfo, 6'h3f);
    chk({rxen, wait_n, breq_n}, 3'h7);
    // random tx control writes, other registers leave outputs alone
    for (i = 0; i < 28; i++)
      set_reg(i % 4, (i % 7 == 6) ? 3'h3 : 3'h5, $random(seed));
    // differential drivers off first, so the wrap below keeps the driver-off order
    set_reg(1, 3'h5, 8'h80);
    // acknowledge cycle must not load the pointer
    i_scc_cpu_model.cyc(port[0], 8'h05, 2, rd);
    @(negedge clk_i);
    chk(kind, SCC_IACK);
    set_reg(0, 3'h5, 8'h80);
    // memory write after a port write must leave the outputs alone
    i_scc_cpu_model.cyc(port[0], 8'hff, 3, rd);
    @(negedge clk_i);
    chk(sfo, exp_sfo());
    chk(kind, SCC_MEM_WR);
    wb(0, `SCC_OFF_CYC, 32'h0);
    chk(q, {24'h0, port[0][4:0], SCC_MEM_WR});
    // hood sense follows the lamp through the probe
    for (i = 0; i < 8; i++)
    begin
      fitted = i[0];
      set_reg(3, 3'h5, $random(seed));
      fork
        i_scc_cpu_model.cyc(port[1], 8'h00, 1, rd);
        begin
          @(posedge clk_i);
          @(negedge clk_i);
          chk(oe, 1);
        end
      join
      chk(rd[5], fitted & ~r5[3][7]);
      @(negedge clk_i);
      chk(oe, 0);
    end
    // wait held: cycle stretched, outputs unchanged until release
    wb(1, `SCC_OFF_CTRL, 32'h1);
    chk(wait_n, 0);
    fork
      set_reg(0, 3'h5, 8'h00);
      begin
        repeat (12) @(posedge clk_i);
        chk(sfo, exp_sfo());
        wb(1, `SCC_OFF_CTRL, 32'h0);
      end
    join
    // bus takeover request and grant
    wb(1, `SCC_OFF_CTRL, 32'h2);
    chk(breq_n, 0);
    wb(0, `SCC_OFF_CTRL, 32'h0);
    chk(q, 32'h2);
    repeat (3) @(posedge clk_i);
    wb(0, `SCC_OFF_STAT, 32'h0);
    chk(q[7:0], {1'b1, fitted & ~r5[3][7], exp_sfo()});
    wb(1, `SCC_OFF_CTRL, 32'h0);
    wb(0, 8'hfc, 32'h0);
    chk(q, 0);
    tally_and_finish();
  end
endmodule : tb_serial_card_control_lines
